// ===== rtl/ifd_pkg.sv
// package: field layout, class codes and timing for the instruction decoder
package ifd_pkg;
  localparam int unsigned WORD_W = 14;
  localparam int unsigned FILE_W = 7;
  localparam int unsigned LIT8_W = 8;
  localparam int unsigned LIT11_W = 11;
  localparam int unsigned BITNUM_W = 3;
  // field positions
  localparam int unsigned BYTE_OP_HI = 13;
  localparam int unsigned BYTE_OP_LO = 8;
  localparam int unsigned DEST_POS = 7;
  localparam int unsigned FILE_HI = 6;
  localparam int unsigned BIT_OP_LO = 10;
  localparam int unsigned BITNUM_HI = 9;
  localparam int unsigned BITNUM_LO = 7;
  localparam int unsigned LIT8_HI = 7;
  localparam int unsigned LONG_OP_LO = 11;
  localparam int unsigned LIT11_HI = 10;
  // file address range
  localparam logic [6:0] FILE_MIN = 7'h00;
  localparam logic [6:0] FILE_MAX = 7'h7f;
  // timing: oscillator periods per instruction cycle
  localparam logic [1:0] PHASES_PER_CYCLE_M1 = 2'h3;
  localparam logic [1:0] PHASE_RST = 2'h0;
  // top-two-bit class codes
  localparam logic [1:0] TOP_BYTE = 2'h0;
  localparam logic [1:0] TOP_BIT = 2'h1;
  localparam logic [1:0] TOP_LONG = 2'h2;
  localparam logic [1:0] TOP_LIT = 2'h3;
  // bit op codes inside the bit class (bits 11:10)
  localparam logic [1:0] BITOP_TEST_CLR = 2'h2;
  localparam logic [1:0] BITOP_TEST_SET = 2'h3;
  // byte-class opcodes that test and skip
  localparam logic [5:0] OPC_DEC_SKIP = 6'h0b;
  localparam logic [5:0] OPC_INC_SKIP = 6'h0f;
  // control words whose upper seven bits are zero
  localparam logic [13:0] WORD_RETURN = 14'h0008;
  localparam logic [13:0] WORD_RETFIE = 14'h0009;
  // literal class: return-with-literal opcodes (bits 13:10 = 4'hd)
  localparam logic [3:0] LIT_RET_HI = 4'hd;

  typedef enum logic [1:0] {
    IFD_FMT_BYTE = 2'b00,
    IFD_FMT_BIT = 2'b01,
    IFD_FMT_LIT = 2'b10,
    IFD_FMT_LONG = 2'b11
  } ifd_fmt_type;

  typedef struct packed {
    ifd_fmt_type fmt;
    logic [5:0] opcode;
    logic dest_file;
    logic [6:0] file_addr;
    logic [2:0] bit_num;
    logic [7:0] lit8;
    logic [10:0] lit11;
    logic is_test;
    logic is_branch;
  } ifd_fields_type;
endpackage : ifd_pkg

// ===== rtl/ifd_field_split.sv
`timescale 1ns/100ps
// leaf: splits one instruction word into its format fields
module ifd_field_split (
  // word in
  input wire logic [13:0] word,
  // fields out
  output ifd_pkg::ifd_fields_type fields
);
  logic [1:0] top;
  assign top = word[13:12];

  // pick format from the top bits; every field is extracted, format tells
  // which apply, so unused positions are simply ignored
  always_comb begin
    fields = '0;
    fields.opcode = word[ifd_pkg::BYTE_OP_HI:ifd_pkg::BYTE_OP_LO];
    fields.dest_file = word[ifd_pkg::DEST_POS];
    fields.file_addr = word[ifd_pkg::FILE_HI:0];
    fields.bit_num = word[ifd_pkg::BITNUM_HI:ifd_pkg::BITNUM_LO];
    fields.lit8 = word[ifd_pkg::LIT8_HI:0];
    fields.lit11 = word[ifd_pkg::LIT11_HI:0];
    case (top)
      ifd_pkg::TOP_BYTE: begin
        fields.fmt = ifd_pkg::IFD_FMT_BYTE;
        fields.is_test = (fields.opcode == ifd_pkg::OPC_DEC_SKIP) ||
                         (fields.opcode == ifd_pkg::OPC_INC_SKIP);
        fields.is_branch = (word == ifd_pkg::WORD_RETURN) ||
                           (word == ifd_pkg::WORD_RETFIE);
        // any file-target write of the program counter redirects flow,
        // the plain store from the accumulator (opcode zero) included
        if (word[ifd_pkg::DEST_POS] && word[6:0] == 7'h02) begin
          fields.is_branch = 1'b1;
        end
      end
      ifd_pkg::TOP_BIT: begin
        fields.fmt = ifd_pkg::IFD_FMT_BIT;
        fields.opcode = {2'h0, word[13:ifd_pkg::BIT_OP_LO]};
        fields.is_test = (word[11:10] == ifd_pkg::BITOP_TEST_CLR) ||
                         (word[11:10] == ifd_pkg::BITOP_TEST_SET);
      end
      ifd_pkg::TOP_LONG: begin
        fields.fmt = ifd_pkg::IFD_FMT_LONG;
        fields.opcode = {3'h0, word[13:ifd_pkg::LONG_OP_LO]};
        fields.is_branch = 1'b1;
      end
      ifd_pkg::TOP_LIT: begin
        fields.fmt = ifd_pkg::IFD_FMT_LIT;
        fields.is_branch = (word[13:10] == ifd_pkg::LIT_RET_HI);
      end
      default: fields.fmt = ifd_pkg::IFD_FMT_BYTE;
    endcase
  end
endmodule // ifd_field_split

// ===== rtl/ifd_decoder.sv
`timescale 1ns/100ps
// top: instruction format decoder with four-phase cycle timing

// Overview of operation
// - each instruction is one 14-bit word of opcode plus operand fields.
// - file operand addresses registers 0x00 through 0x7F.
// - destination bit clear sends result to accumulator, set to file.
// - don't-care bits are ignored; tools should write them as zero.
// - one cycle per instruction; true test or flow change takes two.
// - one instruction cycle is exactly four oscillator periods.
// - byte format: opcode 13:8, destination 7, file address 6:0.
// - bit format yields a bit number and a 7-bit file address.
// - literal format: opcode 13:8, 8-bit constant 7:0.
// - call and jump: opcode 13:11, 11-bit target 10:0.
module ifd_decoder (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // program memory side
  input wire logic [13:0] instr_word,
  input wire logic instr_valid,
  input wire logic cond_true,
  // execution side; fetch_ready goes back to program memory
  output ifd_pkg::ifd_fields_type fields_out,
  output logic fields_valid,
  output logic phase_start,
  output logic [1:0] phase,
  output logic no_operation,
  output logic fetch_ready
);
  typedef enum logic [1:0] {
    IFD_ST_RUN = 2'b00,
    IFD_ST_EXEC = 2'b01,
    IFD_ST_FLUSH = 2'b10
  } ifd_state_type;

  ifd_pkg::ifd_fields_type split_fields;
  logic [1:0] phase_reg, phase_next;
  ifd_state_type state_reg, state_next;
  ifd_pkg::ifd_fields_type fields_reg, fields_next;
  logic valid_reg, valid_next;
  logic nop_reg, nop_next;
  logic cycle_end;

  ifd_field_split u_split (
    .word(instr_word),
    .fields(split_fields)
  );

  // phase counter: wraps every four oscillator periods
  always_comb begin
    phase_next = (phase_reg == ifd_pkg::PHASES_PER_CYCLE_M1) ?
                 ifd_pkg::PHASE_RST : phase_reg + 2'h1;
  end
  assign cycle_end = (phase_reg == ifd_pkg::PHASES_PER_CYCLE_M1);

  // instruction cycle sequencing; a word is only taken at a cycle boundary
  // so that the whole four-phase slot belongs to one instruction
  always_comb begin
    state_next = state_reg;
    fields_next = fields_reg;
    valid_next = valid_reg;
    nop_next = nop_reg;
    if (cycle_end) begin
      case (state_reg)
        IFD_ST_RUN, IFD_ST_EXEC: begin
          nop_next = 1'b0;
          valid_next = instr_valid;
          if (instr_valid) begin
            fields_next = split_fields;
            // second cycle only for taken tests or flow changes
            if (split_fields.is_branch ||
                (split_fields.is_test && cond_true)) begin
              state_next = IFD_ST_FLUSH;
            end else begin
              state_next = IFD_ST_EXEC;
            end
          end else begin
            state_next = IFD_ST_RUN;
          end
        end
        IFD_ST_FLUSH: begin
          // second cycle runs as a no-operation, nothing fetched
          valid_next = 1'b0;
          nop_next = 1'b1;
          state_next = IFD_ST_RUN;
        end
        default: state_next = IFD_ST_RUN;
      endcase
    end
  end

  // register all state
  always_ff @(posedge mclk) begin
    if (srst) begin
      phase_reg <= ifd_pkg::PHASE_RST;
      state_reg <= IFD_ST_RUN;
      fields_reg <= '0;
      valid_reg <= 1'b0;
      nop_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      state_reg <= state_next;
      fields_reg <= fields_next;
      valid_reg <= valid_next;
      nop_reg <= nop_next;
    end
  end

  assign fields_out = fields_reg;
  assign fields_valid = valid_reg;
  assign no_operation = nop_reg;
  assign phase = phase_reg;
  assign phase_start = (phase_reg == ifd_pkg::PHASE_RST);
  // fetch is accepted only at a boundary not swallowed by a flush
  assign fetch_ready = cycle_end && (state_reg != IFD_ST_FLUSH);

  // ---- checks ----
  sequence cycle_seq;
    phase_reg == 2'h0 ##1 phase_reg == 2'h1 ##1 phase_reg == 2'h2
      ##1 phase_reg == 2'h3;
  endsequence

  phase_wrap_a: assert property (@(posedge mclk) disable iff (srst)
    phase_reg == 2'h0 |-> cycle_seq ##1 phase_reg == 2'h0)
    else $error("phase does not wrap after four periods");

  flush_nop_a: assert property (@(posedge mclk) disable iff (srst)
    (cycle_end && state_reg == IFD_ST_FLUSH) |=> no_operation [*4])
    else $error("second cycle is not a no-operation");

  taken_two_a: assert property (@(posedge mclk) disable iff (srst)
    (cycle_end && state_reg != IFD_ST_FLUSH && instr_valid &&
     split_fields.is_branch) |=> ##3 (cycle_end && state_reg == IFD_ST_FLUSH))
    else $error("flow change did not take a second cycle");

  single_cycle_a: assert property (@(posedge mclk) disable iff (srst)
    (cycle_end && state_reg != IFD_ST_FLUSH && instr_valid &&
     !split_fields.is_branch && !split_fields.is_test)
     |=> !no_operation [*4])
    else $error("plain instruction took an extra cycle");

  byte_split_a: assert property (@(posedge mclk) disable iff (srst)
    (fetch_ready && instr_valid && instr_word[13:12] == 2'h0) |=>
     fields_out.opcode == $past(instr_word[13:8]) &&
     fields_out.dest_file == $past(instr_word[7]) &&
     fields_out.file_addr == $past(instr_word[6:0]))
    else $error("byte format fields wrong");

  bit_split_a: assert property (@(posedge mclk) disable iff (srst)
    (fetch_ready && instr_valid && instr_word[13:12] == 2'h1) |=>
     fields_out.fmt == ifd_pkg::IFD_FMT_BIT &&
     fields_out.bit_num == $past(instr_word[9:7]) &&
     fields_out.opcode[3:0] == $past(instr_word[13:10]))
    else $error("bit format fields wrong");

  lit_split_a: assert property (@(posedge mclk) disable iff (srst)
    (fetch_ready && instr_valid && instr_word[13:12] == 2'h3) |=>
     fields_out.lit8 == $past(instr_word[7:0]) &&
     fields_out.opcode == $past(instr_word[13:8]))
    else $error("literal format fields wrong");

  long_split_a: assert property (@(posedge mclk) disable iff (srst)
    (fetch_ready && instr_valid && instr_word[13:12] == 2'h2) |=>
     fields_out.fmt == ifd_pkg::IFD_FMT_LONG &&
     fields_out.lit11 == $past(instr_word[10:0]) &&
     fields_out.opcode[2:0] == $past(instr_word[13:11]))
    else $error("long jump fields wrong");

  hold_slot_a: assert property (@(posedge mclk) disable iff (srst)
    (!cycle_end) |=> $stable(fields_out))
    else $error("fields changed inside a cycle");
endmodule // ifd_decoder

// ===== tb/ifd_prog_mem.sv
// program memory model that offers one instruction word at a time
`timescale 1ns/100ps
module ifd_prog_mem (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // load from bench
  input wire logic load_en,
  input wire logic [13:0] load_word,
  input wire logic load_cond,
  // decoder side
  input wire logic fetch_ready,
  output logic [13:0] instr_word,
  output logic instr_valid,
  output logic cond_true
);
  // hold the word until taken, then show its inverse so stale data shows up
  always_ff @(posedge mclk) begin
    if (srst) begin
      instr_word <= 14'h0000;
      instr_valid <= 1'b0;
      cond_true <= 1'b0;
    end else if (load_en) begin
      instr_word <= load_word;
      instr_valid <= 1'b1;
      cond_true <= load_cond;
    end else if (instr_valid && fetch_ready) begin
      instr_word <= ~instr_word;
      instr_valid <= 1'b0;
      cond_true <= ~cond_true;
    end
  end
endmodule // ifd_prog_mem

// ===== tb/tb_instruction_format_decode.sv
// self-checking bench for the instruction format decoder
`timescale 1ns/100ps
module tb_instruction_format_decode;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic load_en = 1'b0;
  logic [13:0] load_word = 14'h0000;
  logic load_cond = 1'b0;
  logic [13:0] instr_word;
  logic instr_valid, cond_true, fields_valid, phase_start;
  logic no_operation, fetch_ready;
  logic [1:0] phase;
  ifd_pkg::ifd_fields_type fo;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  ifd_decoder DUT (.mclk(mclk), .srst(srst), .instr_word(instr_word),
    .instr_valid(instr_valid), .cond_true(cond_true), .fields_out(fo),
    .fields_valid(fields_valid), .phase_start(phase_start), .phase(phase),
    .no_operation(no_operation), .fetch_ready(fetch_ready));
  ifd_prog_mem pmem (.mclk(mclk), .srst(srst), .load_en(load_en),
    .load_word(load_word), .load_cond(load_cond), .fetch_ready(fetch_ready),
    .instr_word(instr_word), .instr_valid(instr_valid),
    .cond_true(cond_true));
  initial begin
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // a hang costs a mismatch rather than a silent stall
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      close_out();
    end
  end
  // a test costs a second cycle only when its condition holds
  function automatic logic exp_test(input logic [13:0] w);
    return (w[13:12] == ifd_pkg::TOP_BYTE && (w[13:8] == ifd_pkg::OPC_DEC_SKIP
      || w[13:8] == ifd_pkg::OPC_INC_SKIP)) || (w[13:12] == ifd_pkg::TOP_BIT
      && w[11] == 1'b1);
  endfunction
  // a flow change always costs a second cycle
  function automatic logic exp_branch(input logic [13:0] w);
    return w[13:12] == ifd_pkg::TOP_LONG || w == ifd_pkg::WORD_RETURN ||
      w == ifd_pkg::WORD_RETFIE || w[13:10] == ifd_pkg::LIT_RET_HI ||
      (w[13:12] == ifd_pkg::TOP_BYTE && w[7] && w[6:0] == 7'h02);
  endfunction
  // offer one word, then follow its execution cycle by cycle
  task automatic run(input logic [13:0] w, input logic c);
    logic two;
    int n;
    ifd_pkg::ifd_fmt_type f;
    two = (exp_test(w) && c) || exp_branch(w);
    f = w[13:12] == 2'h0 ? ifd_pkg::IFD_FMT_BYTE : w[13:12] == 2'h1 ?
      ifd_pkg::IFD_FMT_BIT : w[13:12] == 2'h2 ? ifd_pkg::IFD_FMT_LONG :
      ifd_pkg::IFD_FMT_LIT;
    @(posedge mclk);
    load_en <= 1'b1;
    load_word <= w;
    load_cond <= c;
    @(posedge mclk);
    load_en <= 1'b0;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (!(fetch_ready === 1'b1 && instr_valid) && n < 20);
    chk(n < 20, "word never taken");
    for (int i = 0; i < (two ? 8 : 4); i++) begin
      @(posedge mclk);
      #1;
      chk(phase === i[1:0] && phase_start === (i[1:0] == 2'h0), "phase");
      if (i < 4) chk(fields_valid === 1'b1 && no_operation === 1'b0, "exec");
      else chk(fields_valid === 1'b0 && no_operation === 1'b1, "flush");
      if (i == 3) chk(fetch_ready === !two, "fetch ready");
    end
    chk(fo.fmt === f, "format");
    chk(fo.is_test === exp_test(w) && fo.is_branch === exp_branch(w),
      "class flags");
    case (w[13:12])
      2'h0: chk(fo.opcode === w[13:8] && fo.dest_file === w[7] &&
        fo.file_addr === w[6:0], "byte fields");
      2'h1: chk(fo.bit_num === w[9:7] && fo.file_addr === w[6:0],
        "bit fields");
      2'h2: chk(fo.lit11 === w[10:0], "long target");
      default: chk(fo.opcode === w[13:8] && fo.lit8 === w[7:0], "literal");
    endcase
  endtask
  task automatic t_reset();
    chk(fields_valid === 1'b0 && no_operation === 1'b0 &&
      fetch_ready === 1'b0 && fo === '0 &&
      phase === ifd_pkg::PHASE_RST, "reset state");
    $display("test reset done");
  endtask
  // these words keep don't-care bits at zero and avoid the legacy loads
  task automatic t_byte();
    run(14'h077f, 1'b1);
    run(14'h0880, 1'b0);
    run(14'h0b80, 1'b1);
    run(14'h0f05, 1'b0);
    run(14'h0082, 1'b0);
    run(14'h0002, 1'b1);
    $display("test byte done");
  endtask
  task automatic t_bit();
    run(14'h13ff, 1'b1);
    run(14'h1800, 1'b1);
    run(14'h1c85, 1'b0);
    $display("test bit done");
  endtask
  task automatic t_ctrl();
    run(14'h3e5a, 1'b1);
    run(14'h34a5, 1'b0);
    run(14'h27ff, 1'b0);
    run(14'h2800, 1'b0);
    run(14'h0008, 1'b0);
    run(14'h0009, 1'b0);
    run(14'h0000, 1'b0);
    // don't-care bits set to one must not change timing; opcode and file fields still carry them
    run(14'h0060, 1'b0);
    run(14'h37a5, 1'b0);
    $display("test control done");
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    // look at the state the last reset edge left, before phase moves on
    #1;
    t_reset();
    t_byte();
    t_bit();
    t_ctrl();
    close_out();
  end
endmodule // tb_instruction_format_decode
